// ===== common/bus_ctl_if.sv
// Carrier between the controller core and its register slave.
// Assumes both ends run from the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface bus_ctl_if;
  import bus_ctl_pkg::*;
  logic             sw_enable;  // Software permission to serve cycles.
  bus_state_e       state;      // Current bus state.
  logic [2:0]       ctype;      // Code of the current cycle.
  logic             selected;   // Cycle was selected at end of status.
  logic             strap;      // Synchronised timing strap.
  logic [15:0]      cycles;     // Completed cycle count.
  modport core (input sw_enable, output state, ctype, selected, strap, cycles);
  modport regs (output sw_enable, input state, ctype, selected, strap, cycles);
endinterface : bus_ctl_if
`default_nettype wire

// ===== common/bus_ctl_pkg.sv
// Shared constants and types for the local bus command controller.
// Assumes all users import the whole package; no other file defines these.
package bus_ctl_pkg;

  // Register byte offsets on the Wishbone side.
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STAT_OFS       = 8'h04;
  localparam logic [7:0] CNT_OFS        = 8'h08;

  // Field positions and reset values of the registers.
  localparam int         CTRL_EN_BIT    = 0;
  localparam logic       CTRL_EN_RST    = 1'h1;
  localparam int         STAT_CTYPE_LSB = 0;
  localparam int         STAT_STATE_LSB = 4;
  localparam int         STAT_SEL_BIT   = 8;
  localparam int         STAT_STRAP_BIT = 9;

  // Falling edges between grant and command drive in compatible mode.
  localparam logic [1:0] GRANT_CMD_EDGES = 2'h3;

  // Reset value of the pin synchronisers; status and ready idle high.
  localparam logic [7:0] SYNC_RST       = 8'hF0;

  // Cycle codes: {mem_io_sel, status_hi_n, status_lo_n}.
  localparam logic [2:0] CODE_IRQ_ACK_CMD_N      = 3'h0;
  localparam logic [2:0] CODE_IO_RD     = 3'h1;
  localparam logic [2:0] CODE_IO_WR     = 3'h2;
  localparam logic [2:0] CODE_MEM_RD    = 3'h5;
  localparam logic [2:0] CODE_MEM_WR    = 3'h6;

  // Bus states; the status state holds only its second phase.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STATUS,
    ST_CMD_PH1,
    ST_CMD_PH2
  } bus_state_e;

  // True for the three read cycle codes.
  function automatic logic is_read(input logic [2:0] code);
    is_read = (code == CODE_IRQ_ACK_CMD_N) || (code == CODE_IO_RD) || (code == CODE_MEM_RD);
  endfunction : is_read

  // True for the two write cycle codes.
  function automatic logic is_write(input logic [2:0] code);
    is_write = (code == CODE_IO_WR) || (code == CODE_MEM_WR);
  endfunction : is_write

endpackage : bus_ctl_pkg

// ===== hw/bus_ctl_regs.sv
// Classic Wishbone slave holding the control, status and count registers.
// Assumes a single-cycle classic master on the rising edge of the clock.
`timescale 1ns/100ps
`default_nettype none
module bus_ctl_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [7:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_w,
  output logic      [31:0] dat_r,
  output logic             ack,
  bus_ctl_if.regs          bus
);
  import bus_ctl_pkg::*;

  typedef struct packed {
    logic        ack;  // Answer, one cycle after the request is seen.
    logic        en;   // Software enable of the controller.
    logic [31:0] dat;  // Registered read data.
  } regs_s;

  regs_s r_reg;
  regs_s r_next;
  logic  take;

  // Requests are answered in the cycle after they appear; ack then drops.
  always_comb begin
    r_next     = r_reg;
    take       = cyc && stb && !r_reg.ack;
    r_next.ack = take;
    r_next.dat = 32'h0;
    if (take && we && adr == CTRL_OFS && sel[0]) begin
      r_next.en = dat_w[CTRL_EN_BIT];
    end
    if (take && !we) begin
      // Unmapped offsets answer normally with zero data.
      case (adr)
        CTRL_OFS: r_next.dat[CTRL_EN_BIT] = r_reg.en;
        STAT_OFS: begin
          r_next.dat[STAT_CTYPE_LSB +: 3] = bus.ctype;
          r_next.dat[STAT_STATE_LSB +: 2] = bus.state;
          r_next.dat[STAT_SEL_BIT]        = bus.selected;
          r_next.dat[STAT_STRAP_BIT]      = bus.strap;
        end
        CNT_OFS: r_next.dat[15:0] = bus.cycles;
        default: r_next.dat = 32'h0;
      endcase
    end
  end

  // Register update on the rising edge, where the master drives.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{ack: 1'h0, en: CTRL_EN_RST, dat: 32'h0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign ack           = r_reg.ack;
  assign dat_r         = r_reg.dat;
  assign bus.sw_enable = r_reg.en;
endmodule : bus_ctl_regs
`default_nettype wire

// ===== hw/local_bus_command_controller.sv
// Local bus command controller: decodes master status into commands.
// Assumes the bus master asserts status in its clock phase 1 and that
// software reaches the registers over classic Wishbone on SYS_CLK.
`timescale 1ns/100ps
`default_nettype none
module local_bus_command_controller (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        STATUS_HI_N,
  input  wire logic        STATUS_LO_N,
  input  wire logic        MEM_IO_SEL,
  input  wire logic        READY_N,
  input  wire logic        COMMAND_DELAY,
  input  wire logic        LATCHED_SELECT,
  input  wire logic        ENABLE_OR_GRANT,
  input  wire logic        COMPAT_TIMING_STRAP,
  output logic             ADDR_LATCH_EN,
  output logic             CASCADE_ENABLE,
  output logic             TRANSCEIVER_ENABLE,
  output logic             TRANSFER_DIRECTION,
  output logic             MEM_READ_CMD_N,
  output logic             MEM_WRITE_CMD_N,
  output logic             IO_READ_CMD_N,
  output logic             IO_WRITE_CMD_N,
  output logic             IRQ_ACK_CMD_N,
  output logic             CMD_OE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O
);
  import bus_ctl_pkg::*;


  // One struct holds every core register,
  // so the whole state moves at one edge.
  // The next-state process starts from a
  // copy, so every field has a value on
  // every path without long default lists.

  // Whole state of the core; updated on the falling edge only.
  typedef struct packed {
    bus_state_e  st;      // Current bus state.
    logic [2:0]  ctype;   // Cycle code captured when status was seen.
    logic        sel;     // Cycle selected at the end of status.
    logic        cmd_ok;  // Command delay has been seen low.
    logic        cmd;     // Command output active before gating.
    logic        ale;     // Address strobe.
    logic        cascade_enable;     // Cascade enable.
    logic        transceiver_enable;     // Transceiver enable before gating.
    logic        dir;     // Transfer direction, high for write or idle.
    logic [1:0]  gcnt;    // Falling edges counted since grant.
    logic [15:0] cycles;  // Cycles that reached their end.
  } core_s;

  core_s       c_reg;    // Registered state.
  core_s       c_next;   // Next state.
  logic [7:0]  pins_s;   // Synchronised pin inputs.
  logic        st_hi_n;  // Synchronised status high.
  logic        st_lo_n;  // Synchronised status low.
  logic        mio;      // Synchronised memory or I/O select.
  logic        rdy_n;    // Synchronised ready.
  logic        cdly;     // Synchronised command delay.
  logic        lsel;     // Synchronised latched select.
  logic        eog;      // Synchronised enable or grant.
  logic        compat;   // Synchronised timing strap.
  logic [2:0]  code;     // Live cycle code.
  logic        st_act;   // Either status input low.
  logic        start;    // A new cycle begins at this edge.
  logic        term;     // The current cycle ends at this edge.
  logic        cur_rd;   // Captured cycle is a read.
  logic        cur_wr;   // Captured cycle is a write.
  logic        gate_ok;  // Output gate open.
  logic        cmd_on;   // Command drive after gating.


  // The interface carries observed state
  // to the register slave and brings the
  // software enable back; one clock only.
  bus_ctl_if bus ();

  // Synchroniser word, top bit first:
  // status high, status low, select,
  // ready, delay, latched select, gate,
  // strap. Reset keeps status and ready
  // high: no cycle starts or ends while
  // the pipe fills.

  // Every pin passes two falling-edge flip-flops before the core reads it.
  pin_sync #(
    .W       (8),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk (SYS_CLK),
    .rst (RST),
    .d   ({STATUS_HI_N, STATUS_LO_N, MEM_IO_SEL, READY_N,
           COMMAND_DELAY, LATCHED_SELECT, ENABLE_OR_GRANT,
           COMPAT_TIMING_STRAP}),
    .q   (pins_s)
  );


  // Unpack the word into named signals.
  assign {st_hi_n, st_lo_n, mio, rdy_n, cdly, lsel, eog, compat} = pins_s;

  // The live code counts only at the
  // start edge; later, every output reads
  // the captured copy in the state word.

  // Memory or I/O select forms the top bit of the cycle code.
  assign code   = {mio, st_hi_n, st_lo_n};
  assign st_act = !st_hi_n || !st_lo_n;
  assign cur_rd = is_read(c_reg.ctype);
  assign cur_wr = is_write(c_reg.ctype);


  // A cycle in falling edges, counted
  // after the synchronisers:
  //   E0: status seen low in idle or at
  //       the end edge of a cycle; code
  //       captured, strobe and cascade.
  //   E1: end of status; select, enable
  //       and delay sampled; direction.
  //   E2: first command clock; enable on.
  //   E3: second command clock; ready low
  //       ends, ready high waits.
  //   E4: idle; direction rests high.
  //
  // The first status clock is seen two
  // edges late, as the synchronisers take two edges.
  // All outputs land later than on a part
  // that reads raw pins; that was traded
  // for two flip-flops on every pin.
  //
  // Waits come in pairs of clocks, so the
  // master's clock phase survives them.
  // The wait branch touches no output.
  //
  // Halt, idle codes and unselected
  // cycles go back to idle; ready and
  // delay are then ignored, so a stray
  // ready from elsewhere does no harm.
  //
  // A read after a write, or the reverse,
  // drops enable at the end edge and turns
  // direction only at the next edge.
  //
  // The cycle counter wraps; software
  // should take differences of readings.

  // Next-state logic of the bus sequencer.
  always_comb begin
    c_next     = c_reg;
    c_next.ale = 1'h0;
    c_next.cascade_enable = 1'h0;
    term       = 1'h0;
    case (c_reg.st)
      // Nothing in flight; direction rests high.
      ST_IDLE: begin
        c_next.transceiver_enable = 1'h0;
        c_next.dir = 1'h1;
      end
      // Second phase of status; select and delay are sampled here.
      ST_STATUS: begin
        if ((cur_rd || cur_wr) && lsel && bus.sw_enable) begin
          c_next.st     = ST_CMD_PH1;
          c_next.sel    = 1'h1;
          c_next.dir    = cur_wr;
          // An early write enable only where direction is already high.
          c_next.transceiver_enable    = cur_wr && !compat && c_reg.dir;
          c_next.cmd_ok = !cdly;
          c_next.cmd    = !cdly && !compat;
        end else begin
          // Halt, idle code or not selected: quiet until next status.
          c_next.st  = ST_IDLE;
          c_next.sel = 1'h0;
          c_next.transceiver_enable = 1'h0;
          c_next.dir = 1'h1;
          c_next.cmd = 1'h0;
        end
      end
      // First clock of the command state; enable comes on for all types.
      ST_CMD_PH1: begin
        c_next.st     = ST_CMD_PH2;
        c_next.transceiver_enable    = 1'h1;
        c_next.cmd_ok = c_reg.cmd_ok || !cdly;
        c_next.cmd    = c_reg.cmd_ok || !cdly;
      end
      // Second clock of the command state; ready decides the outcome.
      ST_CMD_PH2: begin
        c_next.cmd_ok = c_reg.cmd_ok || !cdly;
        c_next.cmd    = c_reg.cmd_ok || !cdly;
        if (rdy_n) begin
          // Wait state: outputs hold, but the command still comes on if delay falls.
          c_next.st = ST_CMD_PH1;
        end else begin
          // End of cycle: enable drops first, direction later.
          term          = 1'h1;
          c_next.st     = ST_IDLE;
          c_next.cmd    = 1'h0;
          c_next.cmd_ok = 1'h0;
          c_next.transceiver_enable    = 1'h0;
          c_next.sel    = 1'h0;
          c_next.cycles = c_reg.cycles + 16'h1;
        end
      end
      default: begin
        c_next.st = ST_IDLE;
      end
    endcase

    // A new cycle starts from idle or straight out of a finishing cycle.
    start = st_act && (c_reg.st == ST_IDLE || term);
    if (start) begin
      c_next.st    = ST_STATUS;
      c_next.ctype = code;
      c_next.ale   = is_read(code) || is_write(code);
      c_next.cascade_enable   = (code == CODE_IRQ_ACK_CMD_N);
      // Fast writes back to back keep enable high; a read ends it.
      c_next.transceiver_enable   = !compat && is_write(code) && c_reg.dir &&
                     (c_reg.st == ST_IDLE || cur_wr);
      c_next.dir   = c_reg.dir;
    end

    // Grant counter: commands follow grant after three falling edges.
    if (!compat || eog) begin
      c_next.gcnt = 2'h0;
    end else if (c_reg.gcnt != GRANT_CMD_EDGES) begin
      c_next.gcnt = c_reg.gcnt + 2'h1;
    end
  end


  // Reset leaves an idle code, so nothing
  // decodes, and direction high, so the
  // transceivers face the bus at rest.

  // All state moves on the falling edge of the system clock.
  always_ff @(negedge SYS_CLK or posedge RST) begin
    if (RST) begin
      c_reg <= '{st: ST_IDLE, ctype: 3'h7, sel: 1'h0, cmd_ok: 1'h0,
                 cmd: 1'h0, ale: 1'h0, cascade_enable: 1'h0, transceiver_enable: 1'h0,
                 dir: 1'h1, gcnt: 2'h0, cycles: 16'h0};
    end else begin
      c_reg <= c_next;
    end
  end


  // Limitation: the gate pin passes the
  // synchroniser, so it acts two edges
  // late, not at once. A raw pin path to
  // the commands would break the rule
  // that pins pass two flip-flops first.
  //
  // Losing grant restarts the counter, so
  // a regained grant always waits three
  // edges, even in the middle of a cycle.

  // Output gating. In fast mode the enable pin forces commands and
  // transceiver enable inactive without floating them. In compatible
  // mode the pin is an active-low grant: released commands float and
  // enable drops two edges after the pin, and commands wait three edges after grant.
  always_comb begin
    if (compat) begin
      gate_ok = !eog;
      cmd_on  = c_reg.cmd && (c_reg.gcnt == GRANT_CMD_EDGES);
      CMD_OE  = !eog;
    end else begin
      gate_ok = eog;
      cmd_on  = c_reg.cmd && eog;
      CMD_OE  = 1'h1;
    end
  end


  // Commands decode the captured code,
  // not the pins, so a master that moves
  // to its next status early cannot upset
  // the cycle still in flight.
  // One command line per cycle type; all others stay high.
  assign MEM_READ_CMD_N     = !(cmd_on && c_reg.ctype == CODE_MEM_RD);
  assign MEM_WRITE_CMD_N    = !(cmd_on && c_reg.ctype == CODE_MEM_WR);
  assign IO_READ_CMD_N      = !(cmd_on && c_reg.ctype == CODE_IO_RD);
  assign IO_WRITE_CMD_N     = !(cmd_on && c_reg.ctype == CODE_IO_WR);
  assign IRQ_ACK_CMD_N      = !(cmd_on && c_reg.ctype == CODE_IRQ_ACK_CMD_N);
  // Enable is gated; direction, strobe and cascade ignore the gate.
  assign TRANSCEIVER_ENABLE = c_reg.transceiver_enable && gate_ok;
  assign TRANSFER_DIRECTION = c_reg.dir;
  assign ADDR_LATCH_EN      = c_reg.ale;
  assign CASCADE_ENABLE     = c_reg.cascade_enable;


  // These change on the falling edge and
  // are settled half a clock before the
  // rising-edge slave reads them.
  // Observed state for the register slave.
  assign bus.state    = c_reg.st;
  assign bus.ctype    = c_reg.ctype;
  assign bus.selected = c_reg.sel;
  assign bus.strap    = compat;
  assign bus.cycles   = c_reg.cycles;

  // Register slave on the rising edge, where the bus master drives.
  bus_ctl_regs u_regs (
    .clk   (SYS_CLK),
    .rst   (RST),
    .cyc   (WB_CYC_I),
    .stb   (WB_STB_I),
    .we    (WB_WE_I),
    .adr   (WB_ADR_I),
    .sel   (WB_SEL_I),
    .dat_w (WB_DAT_I),
    .dat_r (WB_DAT_O),
    .ack   (WB_ACK_O),
    .bus   (bus)
  );

endmodule : local_bus_command_controller
`default_nettype wire

// ===== hw/pin_sync.sv
// Two-stage synchroniser for the pin inputs, on the falling edge.
// Assumes the pins are asynchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 8,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // Both stages live in one state word; only stage two feeds the output.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // The first stage is read by the second stage alone.
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // Falling edge keeps the sampling on the same edge as the core.
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule : pin_sync
`default_nettype wire

// ===== verif/local_bus_command_controller_sva.sv
// Port checker for the local bus command controller.
// Assumes it is bound to the top module; the core moves on falling edges.
`timescale 1ns/100ps
`default_nettype none
module local_bus_command_controller_sva (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic READY_N,
  input wire logic ENABLE_OR_GRANT,
  input wire logic COMPAT_TIMING_STRAP,
  input wire logic ADDR_LATCH_EN,
  input wire logic CASCADE_ENABLE,
  input wire logic TRANSCEIVER_ENABLE,
  input wire logic TRANSFER_DIRECTION,
  input wire logic MEM_READ_CMD_N,
  input wire logic MEM_WRITE_CMD_N,
  input wire logic IO_READ_CMD_N,
  input wire logic IO_WRITE_CMD_N,
  input wire logic IRQ_ACK_CMD_N,
  input wire logic CMD_OE
);
  logic [4:0] cmd_n;   // All five commands.
  logic       rd_on;   // A read command is active.
  logic       wr_on;   // A write command is active.
  logic [1:0] age_reg; // Edges since reset, saturating.
  assign cmd_n = {MEM_READ_CMD_N, MEM_WRITE_CMD_N, IO_READ_CMD_N, IO_WRITE_CMD_N, IRQ_ACK_CMD_N};
  assign rd_on = !MEM_READ_CMD_N || !IO_READ_CMD_N || !IRQ_ACK_CMD_N;
  assign wr_on = !MEM_WRITE_CMD_N || !IO_WRITE_CMD_N;
  // Gating checks wait until the pin synchronisers have filled after reset.
  always_ff @(negedge SYS_CLK or posedge RST) begin
    if (RST) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking cb @(negedge SYS_CLK); endclocking
  default disable iff (RST);
  a_cascade_in_strobe: assert property (CASCADE_ENABLE |-> ADDR_LATCH_EN)
    else $error("cascade outside strobe");
  a_strobe_spacing: assert property (ADDR_LATCH_EN |=> !ADDR_LATCH_EN [*2])
    else $error("strobe too soon");
  a_single_command: assert property ($onehot0(~cmd_n))
    else $error("two commands at once");
  a_read_dir_low: assert property (rd_on |-> !TRANSFER_DIRECTION)
    else $error("read with direction high");
  a_write_dir_high: assert property (wr_on |-> TRANSFER_DIRECTION)
    else $error("write with direction low");
  a_enable_before_turn: assert property ($changed(TRANSFER_DIRECTION) |->
    !TRANSCEIVER_ENABLE && !$past(TRANSCEIVER_ENABLE)) else $error("direction turned");
  a_wait_holds: assert property ((rd_on || wr_on) && !COMPAT_TIMING_STRAP &&
    READY_N && $past(READY_N) && $past(READY_N, 2) && $past(READY_N, 3) && ENABLE_OR_GRANT
    && $past(ENABLE_OR_GRANT) && $past(ENABLE_OR_GRANT, 2) && $past(ENABLE_OR_GRANT, 3)
    |=> $stable({cmd_n, TRANSFER_DIRECTION})) else $error("output moved in wait");
  a_fast_drives: assert property (age_reg == 2'h3 && !COMPAT_TIMING_STRAP |-> CMD_OE)
    else $error("fast mode tristated");
  a_enable_gates: assert property (age_reg == 2'h3 && !COMPAT_TIMING_STRAP &&
    !ENABLE_OR_GRANT && !$past(ENABLE_OR_GRANT) && !$past(ENABLE_OR_GRANT, 2)
    |-> cmd_n == 5'h1F && !TRANSCEIVER_ENABLE) else $error("gate ignored");
  a_grant_releases: assert property (age_reg == 2'h3 && COMPAT_TIMING_STRAP &&
    ENABLE_OR_GRANT && $past(ENABLE_OR_GRANT) && $past(ENABLE_OR_GRANT, 2)
    |-> !CMD_OE && !TRANSCEIVER_ENABLE) else $error("drove without grant");
  c_read: cover property (rd_on ##1 rd_on [*3]);
  c_write: cover property (wr_on);
  c_cascade: cover property (CASCADE_ENABLE);
endmodule : local_bus_command_controller_sva
bind local_bus_command_controller local_bus_command_controller_sva sva_i (.*);
`default_nettype wire

// ===== verif/local_bus_command_controller_tb_top.sv
// Self-checking bench for the local bus command controller.
// Assumes the master model owns status, select and ready.
`timescale 1ns/100ps
`default_nettype none
module local_bus_command_controller_tb_top;
  import bus_ctl_pkg::*;
  logic        clk, rst, cmd_dly, lat_sel, eog, strap, cyc, stb, we, en_sw;
  logic        hi_n, lo_n, mio, rdy_n, ale, cascade_enable, transceiver_enable, dir, oe, ack;
  logic [7:0]  adr;
  logic [31:0] dat_w, dat_r, q;
  logic [4:0]  cmd_n, cmd_old;
  logic [5:0]  cmd_q[$];  // Expected commands and direction, oldest first.
  logic        ale_q[$];  // Expected cascade level at each strobe.
  logic [2:0]  codes[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  int          error_cnt, checks, i;
  local_bus_command_controller uut (.SYS_CLK(clk), .RST(rst), .STATUS_HI_N(hi_n),
    .STATUS_LO_N(lo_n), .MEM_IO_SEL(mio), .READY_N(rdy_n), .COMMAND_DELAY(cmd_dly),
    .LATCHED_SELECT(lat_sel), .ENABLE_OR_GRANT(eog), .COMPAT_TIMING_STRAP(strap),
    .ADDR_LATCH_EN(ale), .CASCADE_ENABLE(cascade_enable), .TRANSCEIVER_ENABLE(transceiver_enable),
    .TRANSFER_DIRECTION(dir), .MEM_READ_CMD_N(cmd_n[4]), .MEM_WRITE_CMD_N(cmd_n[3]),
    .IO_READ_CMD_N(cmd_n[2]), .IO_WRITE_CMD_N(cmd_n[1]), .IRQ_ACK_CMD_N(cmd_n[0]),
    .CMD_OE(oe), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack));
  local_bus_master_model mdl (.clk(clk), .status_hi_n(hi_n), .status_lo_n(lo_n),
    .mem_io_sel(mio), .ready_n(rdy_n));
  // The clock runs at 125 MHz.
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Compares one value and counts the outcome.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task end_sim;
    if (cmd_q.size() + ale_q.size() != 0) error_cnt++;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // One classic Wishbone cycle; ack is watched where it is settled.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat_w} <= {2'h3, w, a, d};
    // Ack ends this wait; the watchdog cuts it short if ack never comes.
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = dat_r;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
  endtask : wb
  // Notes what a cycle must show, then lets the master run it.
  task bus(input logic [2:0] code, input int waits, input logic s);
    logic [4:0] c;
    case (code)
      3'h5: c = 5'h0F;
      3'h6: c = 5'h17;
      3'h1: c = 5'h1B;
      3'h2: c = 5'h1D;
      3'h0: c = 5'h1E;
      default: c = 5'h1F;
    endcase
    if (c != 5'h1F) ale_q.push_back(code == 3'h0);
    if (c != 5'h1F && s && en_sw) cmd_q.push_back({c, code[1]});
    lat_sel <= s;
    mdl.run(code, waits);
  endtask : bus
  // Ends the ready pulse and lets the bus rest.
  task idle(input int n);
    @(posedge clk);
    mdl.park(1'h1);
    repeat (n) @(posedge clk);
  endtask : idle
  // Resets with the strap given; grant or enable is handed out at once.
  task do_reset(input logic s);
    {rst, strap, eog} <= {1'h1, s, !s};
    mdl.park(1'h0);
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // A strobe or a new command takes the oldest note of its kind.
  always @(posedge clk) begin
    if (ale === 1'h1) begin
      if (ale_q.size() == 0) chk(32'h1, 32'h0);
      else chk(cascade_enable, ale_q.pop_front());
    end
    if (cmd_n !== 5'h1F && cmd_old === 5'h1F) begin
      if (cmd_q.size() == 0) chk({cmd_n, dir}, 32'h40);
      else chk({cmd_n, dir}, cmd_q.pop_front());
    end
    cmd_old = cmd_n;
  end
  // Cuts a hang short.
  initial begin
    #300000;
    error_cnt++;
    end_sim;
  end
  initial begin
    {rst, cmd_dly, lat_sel, strap, cyc, stb, we, eog, en_sw} = 9'h123;
    {adr, dat_w, cmd_old, error_cnt, checks} = '0;
    cmd_old = 5'h1F;
    i = $urandom(72252);
    do_reset(1'h0);
    wb(1'h0, CTRL_OFS, 32'h0);
    chk(q, 32'h1);
    wb(1'h0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    idle(1);
    for (i = 0; i < 5; i++) bus(codes[i], 0, 1'h1);
    idle(4);
    wb(1'h0, CNT_OFS, 32'h0);
    chk(q, 32'h5);
    bus(3'h4, 1, 1'h1);
    bus(3'h3, 0, 1'h1);
    bus(3'h7, 0, 1'h1);
    bus(3'h1, 0, 1'h1);
    bus(3'h5, 1, 1'h0);
    idle(2);
    wb(1'h1, CTRL_OFS, 32'h0);
    en_sw = 1'h0;
    bus(3'h6, 0, 1'h1);
    idle(2);
    wb(1'h1, CTRL_OFS, 32'h1);
    en_sw = 1'h1;
    cmd_dly <= 1'h1;
    fork
      bus(3'h5, 3, 1'h1);
      begin
        repeat (4) @(posedge clk);
        chk(cmd_n, 32'h1F);
        @(posedge clk);
        cmd_dly <= 1'h0;
      end
    join
    for (i = 0; i < 16; i++) bus(codes[$urandom_range(4)], $urandom_range(2), 1'h1);
    cmd_q.push_back(6'h36);
    fork
      bus(3'h1, 3, 1'h1);
      begin
        repeat (5) @(posedge clk);
        eog <= 1'h0;
        repeat (3) @(posedge clk);
        chk({cmd_n, transceiver_enable}, 32'h3E);
        eog <= 1'h1;
      end
    join
    idle(2);
    do_reset(1'h1);
    wb(1'h0, STAT_OFS, 32'h0);
    chk(q[STAT_STRAP_BIT], 32'h1);
    idle(1);
    for (i = 0; i < 10; i++) bus(codes[$urandom_range(4)], 1 + $urandom_range(1), 1'h1);
    idle(2);
    eog <= 1'h1;
    repeat (5) @(posedge clk);
    chk({oe, transceiver_enable}, 32'h0);
    eog <= 1'h0;
    idle(4);
    end_sim;
  end
endmodule : local_bus_command_controller_tb_top
`default_nettype wire

// ===== verif/local_bus_master_model.sv
// Behavioural local bus master: status, memory/IO select and ready.
// Assumes its tasks are entered right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module local_bus_master_model (
  input  wire logic clk,
  output logic      status_hi_n,
  output logic      status_lo_n,
  output logic      mem_io_sel,
  output logic      ready_n
);
  // Status lines rest high on their pull-ups; ready is low for reset.
  initial begin
    status_hi_n = 1'h1;
    status_lo_n = 1'h1;
    mem_io_sel  = 1'h0;
    ready_n     = 1'h0;
  end
  // Parks the bus with no status and ready at the given level.
  task park(input logic rdy);
    status_hi_n <= 1'h1;
    status_lo_n <= 1'h1;
    ready_n     <= rdy;
  endtask : park
  // Two status clocks, then command states; a ready pulse ends the last.
  task run(input logic [2:0] code, input int waits);
    {mem_io_sel, status_hi_n, status_lo_n} <= code;
    @(posedge clk);
    ready_n <= 1'h1;
    @(posedge clk);
    status_hi_n <= 1'h1;
    status_lo_n <= 1'h1;
    // Select is no longer held, so show its inverse, not a stale value.
    mem_io_sel  <= ~code[2];
    repeat (2 * waits + 1) @(posedge clk);
    ready_n <= 1'h0;
  endtask : run
endmodule : local_bus_master_model
`default_nettype wire
